// ---- hw/psm_pkg.sv ----
package psm_pkg;
	// Throttle ratio encodings: slot period = 2^(code+1)
	localparam logic [2:0] RATIO_1_4     = 3'h1;
	localparam int         RATIO_W       = 3;
	localparam int         SLOT_CNT_W    = 8;
	// Interrupt vector address fetched after recovery
	localparam logic [15:0] IRQ_VECTOR   = 16'h0004;
	localparam int         IRQ_SRC_W     = 8;
	// Reset values
	localparam logic       THR_EN_RST    = 1'h0;
	localparam logic       PD_N_RST      = 1'h1;
	localparam logic       TO_N_RST      = 1'h1;

	typedef enum logic [1:0]
	{
		ST_RUN   = 2'h0,
		ST_SLEEP = 2'h1,
		ST_WAKE  = 2'h3,
		ST_IDLE  = 2'h2
	} pmode_t;
endpackage

// ---- hw/psm_sync.sv ----
`timescale 1ns/100ps
// Three-stage synchroniser; a change is taken when stages two and three agree
module psm_sync #(
	parameter int W = 1
)
(
	input  wire logic         sys_clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_t;

	sync_t st_r;
	sync_t st_nxt;

	// Stage one feeds only stage two
	always_comb
	begin
		st_nxt    = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < W; i++)
		begin
			if (st_r.s2[i] == st_r.s3[i])
				st_nxt.q[i] = st_r.s3[i];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign dout = st_r.q;
endmodule

// ---- hw/power_saving_mode_controller.sv ----
`timescale 1ns/100ps
module power_saving_mode_controller #(
	parameter int NSRC = psm_pkg::IRQ_SRC_W
)
(
	input  wire logic                            sys_clk,
	input  wire logic                            arst_n,
	input  wire logic                            throttle_set,
	input  wire logic                            throttle_clr,
	input  wire logic [psm_pkg::RATIO_W-1:0]     throttle_ratio,
	input  wire logic                            recover_on_irq,
	input  wire logic                            slow_on_return,
	input  wire logic                            idle_select,
	input  wire logic                            global_irq_enable,
	input  wire logic                            peripheral_irq_enable,
	input  wire logic [NSRC-1:0]                 irq_flag,
	input  wire logic [NSRC-1:0]                 irq_enable,
	input  wire logic [NSRC-1:0]                 core_irq_flag_group,
	input  wire logic [NSRC-1:0]                 clock_switch_irq,
	input  wire logic                            cycle_boundary,
	input  wire logic                            multi_cycle_busy,
	input  wire logic                            sleep_req,
	input  wire logic                            return_from_interrupt,
	input  wire logic                            prefetch_done,
	input  wire logic                            wdt_expire,
	input  wire logic                            wdt_sleep_en,
	input  wire logic [2:0]                      osc_periph_req,
	input  wire logic [2:0]                      osc_manual_on,
	input  wire logic                            adc_on_rc_clock,
	input  wire logic                            adc_power_on,
	input  wire logic                            pin_periph_active,
	input  wire logic                            program_flash_ready,
	input  wire logic                            current_osc_ready,
	input  wire logic                            brownout_ready,
	input  wire logic                            brownout_disabled,
	output logic                                 throttle_enable,
	output logic                                 cpu_clk_en,
	output logic                                 periph_clk_en,
	output logic                                 sys_clk_en,
	output logic                                 vector_fetch,
	output logic                                 irq_call,
	output logic                                 wdt_clear,
	output logic                                 wdt_run_en,
	output logic                                 wdt_reset_block,
	output logic                                 powerdown_flag_n,
	output logic                                 timeout_flag_n,
	output logic [2:0]                           osc_keep_on,
	output logic                                 adc_abort,
	output logic                                 adc_core_on,
	output logic                                 pin_hold,
	output logic                                 cpu_resume
);
	// Slot period mask for a given ratio code
	function automatic logic [psm_pkg::SLOT_CNT_W-1:0] ratio_mask(input logic [psm_pkg::RATIO_W-1:0] code);
		ratio_mask = psm_pkg::SLOT_CNT_W'((9'h2 << code) - 9'h1);
	endfunction

	typedef struct packed
	{
		psm_pkg::pmode_t                   mode;
		logic                              thr;
		logic [psm_pkg::SLOT_CNT_W-1:0]    slot;
		logic                              vec_pend;
		logic                              in_isr;
		logic                              pd_n;
		logic                              to_n;
		logic                              cpu_en;
		logic                              per_en;
		logic                              sys_en;
		logic                              vec;
		logic                              call;
		logic                              wclr;
		logic                              wrun;
		logic                              wblk;
		logic [2:0]                        osc;
		logic                              abort;
		logic                              adc_on;
		logic                              hold;
		logic                              resume;
		logic                              call_pend;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic   ready_sync;
	logic   ready_raw;
	logic   irq_wake;
	logic   irq_any;

	// Readiness flags come from analog domains, so they are synchronised
	assign ready_raw = program_flash_ready & current_osc_ready & (brownout_ready | brownout_disabled);

	psm_sync #(
		.W(1)
	)
	u_ready_sync
	(
		.sys_clk(sys_clk),
		.arst_n (arst_n),
		.din    (ready_raw),
		.dout   (ready_sync)
	);

	// Qualified wake sources, global enable deliberately ignored
	always_comb
	begin
		irq_wake = 1'b0;
		for (int i = 0; i < NSRC; i++)
		begin
			if (irq_flag[i] && irq_enable[i] && !clock_switch_irq[i]
				&& (core_irq_flag_group[i] || peripheral_irq_enable))
				irq_wake = 1'b1;
		end
		irq_any = irq_wake;
	end

	// Mode sequencing and throttle control
	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.vec    = 1'b0;
		st_nxt.call   = 1'b0;
		st_nxt.wclr   = 1'b0;
		st_nxt.abort  = 1'b0;
		st_nxt.resume = 1'b0;
		st_nxt.wrun   = wdt_sleep_en;
		if (throttle_set)
			st_nxt.thr = 1'b1;
		if (throttle_clr)
			st_nxt.thr = 1'b0;
		unique case (st_r.mode)
			psm_pkg::ST_RUN:
			begin
				// Slot counter advances on each cycle_boundary; peripherals never gated
				st_nxt.per_en = 1'b1;
				st_nxt.sys_en = 1'b1;
				st_nxt.hold   = 1'b0;
				st_nxt.wblk   = 1'b0;
				if (cycle_boundary)
				begin
					st_nxt.slot   = (st_r.slot + 1'b1) & ratio_mask(throttle_ratio);
					st_nxt.cpu_en = !st_nxt.thr || (st_nxt.slot == '0);
				end
				if (irq_any && !st_r.in_isr && global_irq_enable)
				begin
					st_nxt.in_isr   = 1'b1;
					st_nxt.vec_pend = 1'b1;
					if (recover_on_irq)
					begin
						st_nxt.thr    = 1'b0;
						st_nxt.cpu_en = 1'b1;
					end
				end
				else if (irq_any && !st_r.in_isr && recover_on_irq && st_r.thr && prefetch_done)
				begin
					// Prefetched op dropped global enable: still leave throttle
					st_nxt.thr    = 1'b0;
					st_nxt.cpu_en = 1'b1;
				end
				if ((st_r.vec_pend || st_r.call_pend) && prefetch_done && !multi_cycle_busy)
				begin
					st_nxt.vec       = 1'b1;
					st_nxt.call      = 1'b1;
					st_nxt.vec_pend  = 1'b0;
					st_nxt.call_pend = 1'b0;
				end
				if (return_from_interrupt)
				begin
					st_nxt.in_isr = 1'b0;
					if (slow_on_return)
						st_nxt.thr = 1'b1;
				end
				if (sleep_req && !(irq_wake && !global_irq_enable))
				begin
					if (idle_select)
					begin
						st_nxt.mode   = psm_pkg::ST_IDLE;
						st_nxt.cpu_en = 1'b0;
						st_nxt.wblk   = 1'b1;
					end
					else
					begin
						st_nxt.mode   = psm_pkg::ST_SLEEP;
						st_nxt.wclr   = 1'b1;
						st_nxt.pd_n   = 1'b0;
						st_nxt.to_n   = 1'b1;
						st_nxt.cpu_en = 1'b0;
						st_nxt.sys_en = 1'b0;
						st_nxt.per_en = 1'b0;
						st_nxt.osc    = osc_periph_req | osc_manual_on;
						st_nxt.abort  = !adc_on_rc_clock;
						st_nxt.adc_on = adc_on_rc_clock;
						st_nxt.hold   = !pin_periph_active;
					end
				end
			end
			psm_pkg::ST_SLEEP:
			begin
				// Reset sources arrive via arst_n; only interrupts and watchdog here
				st_nxt.osc  = osc_periph_req | osc_manual_on;
				st_nxt.hold = !pin_periph_active;
				if (irq_wake || wdt_expire)
				begin
					st_nxt.mode      = psm_pkg::ST_WAKE;
					st_nxt.wclr      = 1'b1;
					st_nxt.call_pend = irq_wake && global_irq_enable;
				end
			end
			psm_pkg::ST_WAKE:
			begin
				// Clocks come back, CPU held until everything is ready
				st_nxt.sys_en = 1'b1;
				st_nxt.per_en = 1'b1;
				st_nxt.hold   = 1'b0;
				st_nxt.adc_on = adc_power_on;
				if (ready_sync)
				begin
					st_nxt.mode   = psm_pkg::ST_RUN;
					st_nxt.cpu_en = 1'b1;
					st_nxt.resume = 1'b1;
				end
			end
			psm_pkg::ST_IDLE:
			begin
				// Idle keeps peripherals; watchdog expiry wakes, no recovery applied
				if (irq_wake || irq_flag != '0 || wdt_expire)
				begin
					st_nxt.mode   = psm_pkg::ST_RUN;
					st_nxt.cpu_en = 1'b1;
					st_nxt.resume = 1'b1;
					st_nxt.wblk   = 1'b0;
					if (irq_wake && recover_on_irq && !wdt_expire)
						st_nxt.thr = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r        <= '0;
			st_r.mode   <= psm_pkg::ST_RUN;
			st_r.thr    <= psm_pkg::THR_EN_RST;
			st_r.pd_n   <= psm_pkg::PD_N_RST;
			st_r.to_n   <= psm_pkg::TO_N_RST;
			st_r.cpu_en <= 1'b1;
			st_r.per_en <= 1'b1;
			st_r.sys_en <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign throttle_enable  = st_r.thr;
	assign cpu_clk_en       = st_r.cpu_en;
	assign periph_clk_en    = st_r.per_en;
	assign sys_clk_en       = st_r.sys_en;
	assign vector_fetch     = st_r.vec;
	assign irq_call         = st_r.call;
	assign wdt_clear        = st_r.wclr;
	assign wdt_run_en       = st_r.wrun;
	assign wdt_reset_block  = st_r.wblk;
	assign powerdown_flag_n = st_r.pd_n;
	assign timeout_flag_n   = st_r.to_n;
	assign osc_keep_on      = st_r.osc;
	assign adc_abort        = st_r.abort;
	assign adc_core_on      = st_r.adc_on;
	assign pin_hold         = st_r.hold;
	assign cpu_resume       = st_r.resume;

	// Sleep entry clears watchdog and sets flags together
	a_sleep_entry_flags: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(st_r.mode == psm_pkg::ST_SLEEP) |-> wdt_clear && !powerdown_flag_n && timeout_flag_n)
		else $error("sleep entry flags wrong");

	a_sleep_gates_cpu: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_r.mode == psm_pkg::ST_SLEEP) |-> !cpu_clk_en && !sys_clk_en)
		else $error("clocks running in sleep");

	a_wake_clears_wdt: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_r.mode == psm_pkg::ST_SLEEP) ##1 (st_r.mode == psm_pkg::ST_WAKE) |-> wdt_clear)
		else $error("wake without watchdog clear");

	a_wake_waits_ready: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_r.mode == psm_pkg::ST_WAKE) && !ready_sync |=> !cpu_clk_en)
		else $error("resumed before ready");

	a_recover_clears_thr: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_r.mode == psm_pkg::ST_RUN) && irq_any && !st_r.in_isr && global_irq_enable
		&& recover_on_irq && !throttle_set && !sleep_req && !return_from_interrupt |=> !throttle_enable)
		else $error("recovery kept throttle");

	a_return_slow: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_r.mode == psm_pkg::ST_RUN) && return_from_interrupt && slow_on_return && !throttle_clr
		|=> throttle_enable)
		else $error("return did not re-throttle");

	a_sleep_nop: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_r.mode == psm_pkg::ST_RUN) && sleep_req && irq_wake && !global_irq_enable
		|=> (st_r.mode == psm_pkg::ST_RUN) && !wdt_clear && $stable(powerdown_flag_n))
		else $error("sleep not a no-op");

	a_idle_select: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_r.mode == psm_pkg::ST_RUN) && sleep_req && !(irq_wake && !global_irq_enable)
		|=> (st_r.mode == (idle_select ? psm_pkg::ST_IDLE : psm_pkg::ST_SLEEP)) || $past(idle_select) != idle_select
		|| st_r.mode == ($past(idle_select) ? psm_pkg::ST_IDLE : psm_pkg::ST_SLEEP))
		else $error("wrong low-power mode");

	a_vector_waits: assert property (@(posedge sys_clk) disable iff (!arst_n)
		multi_cycle_busy |=> !vector_fetch)
		else $error("vector during multi-cycle op");

	a_periph_running: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_r.mode == psm_pkg::ST_RUN) ##1 (st_r.mode == psm_pkg::ST_RUN) |-> periph_clk_en)
		else $error("peripheral clock gated while throttled");
endmodule

// ---- tb/psm_core_model.sv ----
`timescale 1ns/100ps
// Behavioural core side: boundary strobe, a two-cycle instruction after each
// resume, and flash/oscillator/brown-out readiness that drops while clocks are off
module psm_core_model (
	input  wire logic sys_clk,
	input  wire logic arst_n,
	input  wire logic sys_clk_en,
	input  wire logic cpu_clk_en,
	input  wire logic cpu_resume,
	input  wire logic slow_ready,
	output logic      cycle_boundary,
	output logic      multi_cycle_busy,
	output logic      prefetch_done,
	output logic      program_flash_ready,
	output logic      current_osc_ready,
	output logic      brownout_ready
);
	logic [3:0] rdy_cnt;
	logic [1:0] busy_cnt;
	logic [3:0] lim;

	// One clock per instruction cycle keeps the bench short
	assign cycle_boundary = arst_n;
	// Slow mode makes the wake wait visibly longer
	assign lim = slow_ready ? 4'hc : 4'h2;
	assign program_flash_ready = (rdy_cnt >= lim);
	assign current_osc_ready = (rdy_cnt >= lim - 4'h1);
	assign brownout_ready = (rdy_cnt >= lim);
	// Prefetch only counts once the two-cycle instruction has finished
	assign multi_cycle_busy = (busy_cnt != 2'h0);
	assign prefetch_done = cpu_clk_en && (busy_cnt == 2'h0);

	// Counters move on the falling edge, away from the design's sampling edge
	always_ff @(negedge sys_clk or negedge arst_n)
		if (!arst_n)
		begin
			rdy_cnt  <= 4'h0;
			busy_cnt <= 2'h0;
		end
		else
		begin
			rdy_cnt  <= !sys_clk_en ? 4'h0 : (rdy_cnt == 4'hf ? rdy_cnt : rdy_cnt + 4'h1);
			busy_cnt <= cpu_resume ? 2'h2 : (busy_cnt != 2'h0 ? busy_cnt - 2'h1 : 2'h0);
		end
endmodule

// ---- tb/power_saving_mode_controller_tb.sv ----
`timescale 1ns/100ps
module power_saving_mode_controller_tb;
	logic       sys_clk, arst_n, throttle_set, throttle_clr, recover_on_irq, slow_on_return, idle_select;
	logic       global_irq_enable, peripheral_irq_enable, sleep_req, return_from_interrupt, wdt_expire;
	logic       wdt_sleep_en, adc_on_rc_clock, adc_power_on, pin_periph_active, brownout_disabled, slow_ready;
	logic [2:0] throttle_ratio, osc_periph_req, osc_manual_on, osc_keep_on;
	logic [7:0] irq_flag, irq_enable, core_irq_flag_group, clock_switch_irq, cnt, pcnt;
	logic       cycle_boundary, multi_cycle_busy, prefetch_done, program_flash_ready, current_osc_ready;
	logic       brownout_ready, throttle_enable, cpu_clk_en, periph_clk_en, sys_clk_en, vector_fetch, irq_call;
	logic       wdt_clear, wdt_run_en, wdt_reset_block, powerdown_flag_n, timeout_flag_n, adc_abort, adc_core_on;
	logic       pin_hold, cpu_resume, saw_clr, saw_call, rdy, saw_vec;
	int         err_count, n_checks;

	power_saving_mode_controller i_dut (.sys_clk, .arst_n, .throttle_set, .throttle_clr, .throttle_ratio,
		.recover_on_irq, .slow_on_return, .idle_select, .global_irq_enable, .peripheral_irq_enable, .irq_flag,
		.irq_enable, .core_irq_flag_group, .clock_switch_irq, .cycle_boundary, .multi_cycle_busy, .sleep_req,
		.return_from_interrupt, .prefetch_done, .wdt_expire, .wdt_sleep_en, .osc_periph_req, .osc_manual_on,
		.adc_on_rc_clock, .adc_power_on, .pin_periph_active, .program_flash_ready, .current_osc_ready,
		.brownout_ready, .brownout_disabled, .throttle_enable, .cpu_clk_en, .periph_clk_en, .sys_clk_en,
		.vector_fetch, .irq_call, .wdt_clear, .wdt_run_en, .wdt_reset_block, .powerdown_flag_n, .timeout_flag_n,
		.osc_keep_on, .adc_abort, .adc_core_on, .pin_hold, .cpu_resume);

	psm_core_model i_core (.sys_clk, .arst_n, .sys_clk_en, .cpu_clk_en, .cpu_resume, .slow_ready, .cycle_boundary,
		.multi_cycle_busy, .prefetch_done, .program_flash_ready, .current_osc_ready, .brownout_ready);

	// 25 MHz system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// One-cycle request; returns in the cycle the registered answer shows
	// Nothing is issued after it, so the prefetched op acts as a no-op
	task automatic sleep_pulse();
		sleep_req = 1'b1;
		cyc(1);
		sleep_req = 1'b0;
	endtask

	// Bounded wait for resume, noting watchdog clear, readiness and service call
	task automatic wait_wake(input int lim);
		int n;
		saw_clr = 1'b0;
		saw_call = 1'b0;
		for (n = 0; n < lim && cpu_resume !== 1'b1; n++)
		begin
			cyc(1);
			saw_clr = saw_clr | wdt_clear;
		end
		rdy = program_flash_ready & current_osc_ready & brownout_ready;
		if (n == lim)
		begin
			err_count++;
			results();
		end
		repeat (12)
		begin
			cyc(1);
			saw_call = saw_call | irq_call;
		end
	endtask

	// Count CPU slots and peripheral-clock cycles over a window
	task automatic count_slots(input int n);
		cnt = 8'h0;
		pcnt = 8'h0;
		repeat (n)
		begin
			cyc(1);
			cnt = cnt + {7'h0, cpu_clk_en};
			pcnt = pcnt + {7'h0, periph_clk_en};
		end
	endtask

	// Raise source 0 for n cycles, then settle; notes any vector fetch pulse
	task automatic irq_pulse(input int n);
		saw_vec = 1'b0;
		irq_flag = 8'h01;
		repeat (n)
		begin
			cyc(1);
			saw_vec = saw_vec | vector_fetch;
		end
		irq_flag = 8'h00;
		repeat (4)
		begin
			cyc(1);
			saw_vec = saw_vec | vector_fetch;
		end
	endtask

	task automatic t_refuse();
		irq_flag = 8'h01;
		sleep_pulse();
		check({4'h0, powerdown_flag_n, timeout_flag_n, wdt_clear, cpu_clk_en}, 8'h0d);
		irq_flag = 8'h00;
		cyc(2);
	endtask

	task automatic t_throttle();
		throttle_set = 1'b1;
		cyc(1);
		throttle_set = 1'b0;
		cyc(4);
		count_slots(16);
		check(cnt, 8'h04);
		check(pcnt, 8'h10);
		// Accepted interrupt without recovery: service runs throttled
		global_irq_enable = 1'b1;
		irq_pulse(2);
		check({6'h0, throttle_enable, saw_vec}, 8'h03);
		count_slots(8);
		check(cnt, 8'h02);
		return_from_interrupt = 1'b1;
		cyc(1);
		return_from_interrupt = 1'b0;
		recover_on_irq = 1'b1;
		irq_pulse(3);
		check({6'h0, throttle_enable, saw_vec}, 8'h01);
		count_slots(8);
		check(cnt, 8'h08);
		slow_on_return = 1'b1;
		return_from_interrupt = 1'b1;
		cyc(1);
		return_from_interrupt = 1'b0;
		cyc(2);
		check({7'h0, throttle_enable}, 8'h01);
		// Global enable dropped: no service, yet throttle is still released
		global_irq_enable = 1'b0;
		irq_pulse(4);
		check({6'h0, throttle_enable, saw_vec}, 8'h00);
		throttle_set = 1'b1;
		cyc(1);
		throttle_set = 1'b0;
		throttle_clr = 1'b1;
		check({7'h0, throttle_enable}, 8'h01);
		cyc(1);
		throttle_clr = 1'b0;
		cyc(2);
		check({7'h0, throttle_enable}, 8'h00);
	endtask

	task automatic t_sleep();
		slow_ready = 1'b1;
		global_irq_enable = 1'b1;
		sleep_pulse();
		check({cpu_clk_en, sys_clk_en, periph_clk_en, wdt_clear, powerdown_flag_n, timeout_flag_n}, 8'h05);
		check({1'h0, osc_keep_on, adc_abort, pin_hold, wdt_run_en, adc_core_on}, 8'h5e);
		irq_enable = 8'h06;
		clock_switch_irq = 8'h04;
		irq_flag = 8'h06;
		cyc(20);
		check({6'h0, cpu_clk_en, sys_clk_en}, 8'h00);
		peripheral_irq_enable = 1'b1;
		wait_wake(80);
		check({5'h0, saw_clr, rdy, saw_call}, 8'h07);
		check({7'h0, cpu_clk_en}, 8'h01);
		irq_flag = 8'h00;
		peripheral_irq_enable = 1'b0;
		cyc(4);
		// Wake with global enable clear: no service call, execution in line
		global_irq_enable = 1'b0;
		peripheral_irq_enable = 1'b1;
		sleep_pulse();
		irq_flag = 8'h02;
		wait_wake(80);
		check({6'h0, saw_clr, saw_call}, 8'h02);
		irq_flag = 8'h00;
		peripheral_irq_enable = 1'b0;
		cyc(4);
	endtask

	task automatic t_idle();
		slow_ready = 1'b0;
		global_irq_enable = 1'b0;
		idle_select = 1'b1;
		sleep_pulse();
		check({4'h0, cpu_clk_en, periph_clk_en, sys_clk_en, wdt_reset_block}, 8'h07);
		irq_flag = 8'h80;
		wait_wake(40);
		check({6'h0, saw_call, cpu_clk_en}, 8'h01);
		irq_flag = 8'h00;
		cyc(4);
		// Throttle on going in; the watchdog wake must leave it alone
		throttle_set = 1'b1;
		cyc(1);
		throttle_set = 1'b0;
		sleep_pulse();
		cyc(3);
		wdt_expire = 1'b1;
		wait_wake(40);
		wdt_expire = 1'b0;
		check({6'h0, throttle_enable, wdt_reset_block}, 8'h02);
	endtask

	initial
	begin
		{arst_n, throttle_set, throttle_clr, recover_on_irq, slow_on_return, idle_select} = 6'h0;
		{global_irq_enable, peripheral_irq_enable, sleep_req, return_from_interrupt, wdt_expire} = 5'h0;
		{adc_on_rc_clock, pin_periph_active, brownout_disabled, slow_ready} = 4'h0;
		wdt_sleep_en = 1'b1;
		adc_power_on = 1'b1;
		throttle_ratio = 3'h1;
		osc_periph_req = 3'h1;
		osc_manual_on = 3'h4;
		irq_flag = 8'h00;
		irq_enable = 8'h01;
		core_irq_flag_group = 8'h01;
		clock_switch_irq = 8'h00;
		err_count = 0;
		n_checks = 0;
		cyc(6);
		arst_n = 1'b1;
		cyc(1);
		check({2'h0, throttle_enable, cpu_clk_en, periph_clk_en, sys_clk_en, powerdown_flag_n, timeout_flag_n}, 8'h1f);
		t_refuse();
		t_throttle();
		t_sleep();
		t_idle();
		results();
	end
endmodule
